// file: bench/pbsp_chk.sv
// Concurrent checks on the pins of the burst memory port
`timescale 1ns/10ps
module pbsp_chk (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Strobes, selects and write controls
  input wire logic proc_addr_strobe_n_i,
  input wire logic ctrl_addr_strobe_n_i,
  input wire logic burst_advance_n_i,
  input wire logic global_write_n_i,
  input wire logic byte_write_enable_n_i,
  input wire logic [pbsp_pkg::LANES-1:0] lane_write_sel_n_i,
  input wire logic chip_sel1_n_i,
  input wire logic chip_sel2_i,
  input wire logic chip_sel3_n_i,
  input wire logic out_en_n_i,
  input wire logic sleep_req_i,
  // Device outputs
  input wire logic [pbsp_pkg::DATA_W-1:0] lane_data_o,
  input wire logic [pbsp_pkg::LANES-1:0] lane_oe_o,
  input wire logic sleeping_o
);
  logic sel;
  logic pstb;
  logic cstb;
  logic desel;
  logic rd_go;
  logic wr_go;
  logic quiet;
  logic [3:0] wm;

  // Decode the sampled cycle the way the pins define it
  assign sel = !chip_sel1_n_i && chip_sel2_i && !chip_sel3_n_i;
  assign pstb = !proc_addr_strobe_n_i && !chip_sel1_n_i;
  assign cstb = !ctrl_addr_strobe_n_i && !pstb;
  assign desel = (pstb || cstb) && !sel;
  assign wm = !global_write_n_i ? 4'hf :
    (!byte_write_enable_n_i ? ~lane_write_sel_n_i : 4'h0);
  assign rd_go = sel && !sleep_req_i && (pstb || (cstb && wm == 4'h0));
  assign wr_go = sel && !sleep_req_i && cstb && wm != 4'h0;
  assign quiet = proc_addr_strobe_n_i && ctrl_addr_strobe_n_i &&
    wm == 4'h0 && !sleep_req_i;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  oe_async_a: assert property (out_en_n_i |-> lane_oe_o == 4'h0)
    else $error("lanes driven while output enable is off");
  wr_release_a: assert property (wr_go |=> lane_oe_o == 4'h0)
    else $error("lanes driven after a write");
  rd_drive_a: assert property (
    rd_go ##1 quiet |=> out_en_n_i || lane_oe_o == 4'hf)
    else $error("read result not driven");
  first_mask_a: assert property (
    desel ##1 rd_go |=> lane_oe_o == 4'h0)
    else $error("first read cycle after deselect driven");
  desel_off_a: assert property (
    desel ##1 (quiet || desel) |=> lane_oe_o == 4'h0)
    else $error("lanes driven after deselect");
  sleep_flag_a: assert property (sleep_req_i |=> sleeping_o)
    else $error("sleep request not followed");
  sleep_hold_a: assert property (
    sleeping_o && $past(sleeping_o) |-> $stable(lane_data_o) &&
    lane_oe_o == 4'h0)
    else $error("activity while asleep");
  lane_same_a: assert property (lane_oe_o == {4{lane_oe_o[0]}})
    else $error("lane drive enables differ");

  cover property (rd_go ##1 !burst_advance_n_i);
  cover property (wr_go);
  cover property (desel ##1 rd_go);
endmodule : pbsp_chk

bind pbsp_core pbsp_chk i_pbsp_chk (.clock_i, .arst_n_i,
  .proc_addr_strobe_n_i, .ctrl_addr_strobe_n_i, .burst_advance_n_i,
  .global_write_n_i, .byte_write_enable_n_i, .lane_write_sel_n_i,
  .chip_sel1_n_i, .chip_sel2_i, .chip_sel3_n_i, .out_en_n_i,
  .sleep_req_i, .lane_data_o, .lane_oe_o, .sleeping_o);

// file: bench/pbsp_host.sv
// Host bus model: drives the controls and resolves the shared lanes
`timescale 1ns/10ps
module pbsp_host (
  // Clock
  input wire logic clock_i,
  // Device drive of the lanes
  input wire logic [35:0] dev_i,
  input wire logic [3:0] dev_oe_i,
  // Controls and resolved lanes
  output logic [18:0] addr_o,
  output logic [8:0] ctl_o,
  output logic [3:0] lsel_o,
  output logic [35:0] bus_o
);
  logic [35:0] drv_r;
  logic drv_en_r;
  logic [35:0] last_r;

  // Start deselected with nothing on the lanes
  initial begin
    ctl_o = 9'h0df;
    addr_o = 19'h0;
    lsel_o = 4'hf;
    drv_r = 36'h0;
    drv_en_r = 1'b0;
    last_r = 36'h0;
  end

  // Released lanes flip every cycle so a stale value never passes
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      bus_o[8*l +: 8] = drv_en_r ? drv_r[8*l +: 8] :
        (dev_oe_i[l] ? dev_i[8*l +: 8] : ~last_r[8*l +: 8]);
      bus_o[32+l] = drv_en_r ? drv_r[32+l] :
        (dev_oe_i[l] ? dev_i[32+l] : ~last_r[32+l]);
    end
  end

  // Remember the wire for the release pattern
  always @(posedge clock_i) begin
    last_r <= bus_o;
  end

  // One bus cycle, changed just after the edge and held a full period
  task put(input logic [8:0] c, input logic [18:0] a, input logic [3:0] ls,
           input logic [35:0] d, input logic hd);
    @(posedge clock_i);
    ctl_o <= c;
    addr_o <= a;
    lsel_o <= ls;
    drv_r <= d;
    drv_en_r <= hd;
  endtask : put
endmodule : pbsp_host

// file: bench/testbench.sv
// Self-checking bench for the burst memory port
`timescale 1ns/10ps
module testbench;
  // Control words {sleep, sel1_n, sel2, sel3_n, pstb_n, cstb_n, adv_n,
  // gw_n, bwe_n}
  localparam logic [8:0] RDP = 9'h04f;
  localparam logic [8:0] RDC = 9'h057;
  localparam logic [8:0] WRG = 9'h055;
  localparam logic [8:0] WRB = 9'h056;
  localparam logic [8:0] BOTH = 9'h045;
  localparam logic [8:0] BURST_ADVANCE_N = 9'h05b;
  localparam logic [8:0] HOLD = 9'h05f;
  // Global write with no strobe: the data cycle of a processor write
  localparam logic [8:0] WRN = 9'h05d;
  localparam logic [8:0] IGN = 9'h0cf;
  localparam logic [8:0] DS2 = 9'h015;
  localparam logic [8:0] DS3 = 9'h075;
  localparam logic [8:0] SLP = 9'h155;
  logic clock_i;
  logic arst_n_i;
  logic oe_n;
  logic want_oe_n;
  logic order;
  logic [18:0] addr;
  logic [8:0] ctl;
  logic [3:0] lsel;
  logic [35:0] bus;
  logic [31:0] dout;
  logic [3:0] pout;
  logic [3:0] oe;
  logic wr_ready;
  logic sleeping;
  logic [35:0] mem [16];
  logic [35:0] e0, e1, e2;
  logic v0, v1, v2, sel;
  logic [3:0] base;
  logic [1:0] cnt;
  int miscompares;
  int checks;

  pbsp_core #(.MEM_ADDR_W(6)) i_pbsp_core (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr),
    .proc_addr_strobe_n_i(ctl[4]), .ctrl_addr_strobe_n_i(ctl[3]),
    .burst_advance_n_i(ctl[2]), .global_write_n_i(ctl[1]),
    .byte_write_enable_n_i(ctl[0]), .lane_write_sel_n_i(lsel),
    .chip_sel1_n_i(ctl[7]), .chip_sel2_i(ctl[6]), .chip_sel3_n_i(ctl[5]),
    .out_en_n_i(oe_n), .burst_order_i(order), .sleep_req_i(ctl[8]),
    .lane_data_i(bus[31:0]), .lane_parity_i(bus[35:32]),
    .lane_data_o(dout), .lane_parity_o(pout), .lane_oe_o(oe),
    .wr_ready_o(wr_ready), .sleeping_o(sleeping));

  pbsp_host i_pbsp_host (.clock_i(clock_i), .dev_i({pout, dout}),
    .dev_oe_i(oe), .addr_o(addr), .ctl_o(ctl), .lsel_o(lsel), .bus_o(bus));

  // 25 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------------
  task cmp_word(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  task cmp_flag(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_flag

  task summarize;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  function automatic logic [35:0] pat(input logic [3:0] i,
                                      input logic [3:0] s);
    pat = {i ^ s, s, i + 4'h3, s, i + 4'h2, s, i + 4'h1, s, i};
  endfunction : pat

  // One bus cycle plus a reference model with a two-deep result pipe
  task op(input logic [8:0] c, input logic [3:0] a, input logic [3:0] ls,
          input logic [35:0] d);
    logic ps;
    logic wr;
    logic hit;
    logic [3:0] wm;
    logic [3:0] ad;
    logic [1:0] lo;
    ps = !c[4] && !c[7];
    wm = !c[1] ? 4'hf : (!c[0] ? ~ls : 4'h0);
    hit = 1'b0;
    wr = 1'b0;
    ad = a;
    if (!c[8] && (ps || !c[3])) begin
      sel = !c[7] && c[6] && !c[5];
      base = a;
      cnt = 2'h0;
      hit = sel;
      wr = sel && !ps && wm != 4'h0;
    end else if (!c[8] && sel) begin
      if (!c[2]) cnt = cnt + 2'h1;
      lo = order ? base[1:0] ^ cnt : base[1:0] + cnt;
      ad = {base[3:2], lo};
      hit = 1'b1;
      wr = wm != 4'h0;
    end
    for (int l = 0; l < 4; l++) begin
      if (wr && wm[l]) begin
        mem[ad][8*l +: 8] = d[8*l +: 8];
        mem[ad][32+l] = d[32+l];
      end
    end
    e2 = e1;
    v2 = v1;
    e1 = e0;
    v1 = v0 && !wr;
    e0 = mem[ad];
    v0 = hit && !wr;
    i_pbsp_host.put(c, {15'h0, a}, ls, d, wm != 4'h0);
    oe_n <= want_oe_n;
    #1;
    cmp_flag(oe, (v2 && !oe_n) ? 4'hf : 4'h0);
    if (v2 && !oe_n) cmp_word({pout, dout}, e2);
  endtask : op

  // Strap only moves while reset is held
  task do_reset(input logic ord);
    arst_n_i <= 1'b0;
    @(posedge clock_i);
    order <= ord;
    repeat (11) @(posedge clock_i);
    arst_n_i <= 1'b1;
    sel = 1'b0;
    v0 = 1'b0;
    v1 = 1'b0;
  endtask : do_reset

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_fill;
    for (int i = 0; i < 16; i++) begin
      op(WRG, 4'(i), 4'hf, pat(4'(i), 4'h6));
    end
    op(HOLD, 4'h0, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
    cmp_flag({3'h0, wr_ready}, 4'h1);
  endtask : t_fill

  task t_bytes;
    op(WRB, 4'h5, 4'ha, pat(4'h5, 4'h9));
    op(RDC, 4'h5, 4'h0, pat(4'h5, 4'h3));
    op(HOLD, 4'h0, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
  endtask : t_bytes

  task t_burst(input logic [3:0] a);
    op(RDP, a, 4'hf, 36'h0);
    repeat (3) op(BURST_ADVANCE_N, 4'h0, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
  endtask : t_burst

  task t_strobes;
    op(BOTH, 4'h9, 4'hf, pat(4'h9, 4'hf));
    op(IGN, 4'h3, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
  endtask : t_strobes

  // Processor-started write: the data follows one cycle after the strobe
  task t_pwrite;
    op(RDP, 4'hc, 4'hf, 36'h0);
    op(WRN, 4'h0, 4'hf, pat(4'hc, 4'h2));
    op(HOLD, 4'h0, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
  endtask : t_pwrite

  task t_desel;
    op(RDP, 4'h2, 4'hf, 36'h0);
    op(DS2, 4'h4, 4'hf, pat(4'h4, 4'he));
    op(HOLD, 4'h0, 4'hf, 36'h0);
    op(DS3, 4'h4, 4'hf, pat(4'h4, 4'hd));
    op(RDP, 4'h4, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
  endtask : t_desel

  task t_oe;
    op(RDP, 4'h7, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
    want_oe_n = 1'b1;
    op(HOLD, 4'h0, 4'hf, 36'h0);
    want_oe_n = 1'b0;
    op(HOLD, 4'h0, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
  endtask : t_oe

  task t_sleep;
    op(DS2, 4'h0, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
    repeat (3) op(SLP, 4'h0, 4'hf, pat(4'h0, 4'hb));
    cmp_flag({3'h0, sleeping}, 4'h1);
    op(HOLD, 4'h0, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
    cmp_flag({3'h0, sleeping}, 4'h0);
    op(RDP, 4'h0, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
    op(HOLD, 4'h0, 4'hf, 36'h0);
  endtask : t_sleep

  // Main sequence; memory keeps its contents across the second reset
  initial begin
    arst_n_i = 1'b0;
    oe_n = 1'b0;
    want_oe_n = 1'b0;
    order = 1'b1;
    miscompares = 0;
    checks = 0;
    do_reset(1'b1);
    t_fill();
    t_bytes();
    t_burst(4'h7);
    t_strobes();
    t_pwrite();
    t_desel();
    t_oe();
    t_sleep();
    do_reset(1'b0);
    t_burst(4'h5);
    summarize();
  end

  // Hang guard
  initial begin
    #400000;
    miscompares++;
    summarize();
  end
endmodule : testbench

// file: src/pbsp_buf.sv
// Small ring buffer with valid/ready on both sides and an ordered peek view
`timescale 1ns/10ps
module pbsp_buf #(
  parameter int W = 8,
  parameter int DEPTH = pbsp_pkg::BUF_DEPTH
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  // Entries oldest first, for forwarding
  output logic [DEPTH-1:0][W-1:0] ord_data_o,
  output logic [DEPTH-1:0] ord_valid_o
);

  localparam int PW = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("pbsp_buf: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] rd_ptr_r;
  logic [PW-1:0] wr_ptr_r;
  logic [PW:0] cnt_r;
  logic [PW:0] cnt_nxt;
  logic push;
  logic pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_r[rd_ptr_r];

  // Occupancy after this edge
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Pointers and flags; ready and valid are flops so full/empty are honest
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_ptr_r <= '0;
      wr_ptr_r <= '0;
      cnt_r <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      in_ready_o <= (cnt_nxt != (PW + 1)'(DEPTH));
      out_valid_o <= (cnt_nxt != '0);
    end
  end

  // Storage holds data only, so it needs no reset
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Oldest-first view of what is still waiting
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      ord_data_o[i] = mem_r[rd_ptr_r + PW'(i)];
      ord_valid_o[i] = ((PW + 1)'(i) < cnt_r);
    end
  end

endmodule : pbsp_buf

// file: src/pbsp_core.sv
// Pipelined burst static memory seen from the memory side of its pins
//
// How it works
// - Address taken only on a strobe while every chip select is active.
// - Low two address bits start a burst; a 2-bit beat counter cleared to 0 forms later beats.
// - Processor strobe low stores the whole presented address.
// - Both strobes low together: only the processor strobe counts.
// - Processor strobe is ignored while first chip select is high.
// - Selected only with select1 low, select2 high, select3 low.
// - A lane select writes its lane only when byte write enable is low.
// - Byte writes happen only when byte write enable is sampled low.
// - Global write low writes every lane, ignoring byte controls.
// - Advance low during a burst steps the burst counter.
// - Output enable acts at once: low drives pins, high releases them.
// - First cycle of a read out of deselect keeps pins released.
// - Order strap low picks linear order, high picks interleaved.
// - Sleep input high idles the port and keeps stored contents.
// - Input data and parity lanes are captured on the rising edge.
// - Read data is the word addressed one edge earlier.
// - Each lane is 8 data bits plus one parity bit, four lanes.
// - The burst counter wraps inside its group of four words.
// - Any detected write releases the data pins regardless of enable.
`timescale 1ns/10ps
module pbsp_core #(
  parameter int MEM_ADDR_W = pbsp_pkg::ADDR_W,
  parameter int BUF_DEPTH = pbsp_pkg::BUF_DEPTH
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Address and strobes
  input wire logic [pbsp_pkg::ADDR_W-1:0] addr_i,
  input wire logic proc_addr_strobe_n_i,
  input wire logic ctrl_addr_strobe_n_i,
  input wire logic burst_advance_n_i,
  // Write controls; bit 0 is lane a
  input wire logic global_write_n_i,
  input wire logic byte_write_enable_n_i,
  input wire logic [pbsp_pkg::LANES-1:0] lane_write_sel_n_i,
  // Chip selects
  input wire logic chip_sel1_n_i,
  input wire logic chip_sel2_i,
  input wire logic chip_sel3_n_i,
  // Static and slow controls
  input wire logic out_en_n_i,
  input wire logic burst_order_i,
  input wire logic sleep_req_i,
  // Data and parity lanes, split into in, out and enable
  input wire logic [pbsp_pkg::DATA_W-1:0] lane_data_i,
  input wire logic [pbsp_pkg::PAR_W-1:0] lane_parity_i,
  output logic [pbsp_pkg::DATA_W-1:0] lane_data_o,
  output logic [pbsp_pkg::PAR_W-1:0] lane_parity_o,
  output logic [pbsp_pkg::LANES-1:0] lane_oe_o,
  // Status
  output logic wr_ready_o,
  output logic sleeping_o
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (MEM_ADDR_W < pbsp_pkg::CNT_W || MEM_ADDR_W > pbsp_pkg::ADDR_W)
  begin : g_bad_addr
    $error("pbsp_core: MEM_ADDR_W out of range");
  end

  localparam int MEM_WORDS = 1 << MEM_ADDR_W;
  localparam int AW = pbsp_pkg::ADDR_W;
  localparam int LN = pbsp_pkg::LANES;
  localparam int DW = pbsp_pkg::LANE_DW;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  // Low address bits of a beat from start bits and beat count
  function automatic logic [1:0] burst_low(input logic [1:0] start,
                                           input logic [1:0] cnt,
                                           input logic linear);
    if (linear) begin
      burst_low = start + cnt;
    end else begin
      burst_low = start ^ cnt;
    end
  endfunction : burst_low

  // Lay the selected lanes of a pending write over a word
  function automatic pbsp_pkg::pbsp_word_t lane_merge(
      input pbsp_pkg::pbsp_word_t base,
      input pbsp_pkg::pbsp_word_t upd,
      input logic [LN-1:0] mask);
    lane_merge = base;
    for (int l = 0; l < LN; l++) begin
      if (mask[l]) begin
        lane_merge.data[l*DW +: DW] = upd.data[l*DW +: DW];
        lane_merge.par[l] = upd.par[l];
      end
    end
  endfunction : lane_merge

  // Index into the array from a full address
  function automatic logic [MEM_ADDR_W-1:0] mem_idx(input logic [AW-1:0] a);
    mem_idx = a[MEM_ADDR_W-1:0];
  endfunction : mem_idx

  // ----------------------------------------------------------------------
  // Storage and registers
  // ----------------------------------------------------------------------
  pbsp_pkg::pbsp_word_t mem_r [MEM_WORDS];
  pbsp_pkg::pbsp_state_t state_r;
  pbsp_pkg::pbsp_state_t state_nxt;
  logic [AW-1:0] addr_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [AW-1:0] rd_addr_r;
  logic rd_pend_r;
  logic drive_r;
  pbsp_pkg::pbsp_word_t out_r;

  // ----------------------------------------------------------------------
  // Input decode
  // ----------------------------------------------------------------------
  logic sel_ok;
  logic p_strobe;
  logic c_strobe;
  logic any_strobe;
  logic start;
  logic desel;
  logic in_burst;
  logic [LN-1:0] wmask;
  logic wr_ctl;
  logic wr_now;
  logic rd_now;
  logic [AW-1:0] acc_addr;

  // All three selects must agree before the port counts as selected
  assign sel_ok = !chip_sel1_n_i && chip_sel2_i && !chip_sel3_n_i;

  // Processor strobe needs select 1 low and wins when both strobes fall
  assign p_strobe = !proc_addr_strobe_n_i && !chip_sel1_n_i;
  assign c_strobe = !ctrl_addr_strobe_n_i && !p_strobe;
  assign any_strobe = p_strobe || c_strobe;

  // New accesses are held off while asleep
  assign start = any_strobe && sel_ok && !sleep_req_i;
  assign desel = any_strobe && !sel_ok;
  assign in_burst = (state_r == pbsp_pkg::ST_SEL) && !any_strobe
                    && !sleep_req_i;

  // Global write covers all lanes; byte selects need the enable
  always_comb begin
    if (!global_write_n_i) begin
      wmask = '1;
    end else if (!byte_write_enable_n_i) begin
      wmask = ~lane_write_sel_n_i;
    end else begin
      wmask = '0;
    end
  end
  assign wr_ctl = |wmask;

  // Counter steps on advance only while a burst is running; it wraps
  // within its two bits so a burst stays in its group of four
  always_comb begin
    cnt_nxt = cnt_r;
    if (in_burst && !burst_advance_n_i) begin
      cnt_nxt = cnt_r + pbsp_pkg::CNT_STEP;
    end
  end

  // Strap is read live; it is assumed steady while running
  assign acc_addr = start ? addr_i
                  : {addr_r[AW-1:2],
                     burst_low(addr_r[1:0], cnt_nxt, !burst_order_i)};

  // Processor-started cycles ignore write controls on their first edge
  assign wr_now = (start && c_strobe && wr_ctl) || (in_burst && wr_ctl);
  assign rd_now = (start && (p_strobe || !wr_ctl)) || (in_burst && !wr_ctl);

  // ----------------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------------
  pbsp_pkg::pbsp_wr_t wr_in;
  pbsp_pkg::pbsp_wr_t wr_head;
  logic wr_head_valid;
  logic [BUF_DEPTH-1:0][pbsp_pkg::WR_W-1:0] ord_data;
  logic [BUF_DEPTH-1:0] ord_valid;

  // Data lanes are captured on the same edge as the write controls
  always_comb begin
    wr_in.addr = acc_addr;
    wr_in.mask = wmask;
    wr_in.word.data = lane_data_i;
    wr_in.word.par = lane_parity_i;
  end

  // Sleep stalls the drain so the array stays still; writes are held off
  // too, so the buffer never fills and wr_ready_o stays high
  pbsp_buf #(
    .W(pbsp_pkg::WR_W),
    .DEPTH(BUF_DEPTH)
  ) u_wbuf (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(wr_now),
    .in_ready_o(wr_ready_o),
    .in_data_i(wr_in),
    .out_valid_o(wr_head_valid),
    .out_ready_i(!sleep_req_i),
    .out_data_o(wr_head),
    .ord_data_o(ord_data),
    .ord_valid_o(ord_valid)
  );

  // Array update, lane by lane, from the buffer head
  always_ff @(posedge clock_i) begin
    if (wr_head_valid && !sleep_req_i) begin
      mem_r[mem_idx(wr_head.addr)] <=
        lane_merge(mem_r[mem_idx(wr_head.addr)], wr_head.word, wr_head.mask);
    end
  end

  // ----------------------------------------------------------------------
  // Read path with forwarding of writes still in the buffer
  // ----------------------------------------------------------------------
  pbsp_pkg::pbsp_word_t rd_word;
  pbsp_pkg::pbsp_wr_t ent;

  // Oldest entry first so the newest write to a lane wins
  always_comb begin
    rd_word = mem_r[mem_idx(rd_addr_r)];
    ent = '0;
    for (int i = 0; i < BUF_DEPTH; i++) begin
      ent = ord_data[i];
      if (ord_valid[i] && mem_idx(ent.addr) == mem_idx(rd_addr_r)) begin
        rd_word = lane_merge(rd_word, ent.word, ent.mask);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencing state
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pbsp_pkg::ST_DESEL, pbsp_pkg::ST_SEL: begin
        if (sleep_req_i) begin
          state_nxt = pbsp_pkg::ST_SLEEP;
        end else if (start) begin
          state_nxt = pbsp_pkg::ST_SEL;
        end else if (desel) begin
          state_nxt = pbsp_pkg::ST_DESEL;
        end
      end
      pbsp_pkg::ST_SLEEP: begin
        if (!sleep_req_i) begin
          state_nxt = pbsp_pkg::ST_DESEL;
        end
      end
      default: begin
        state_nxt = pbsp_pkg::ST_DESEL;
      end
    endcase
  end

  // Control flops; the output word and the write buffer flags also see the reset
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= pbsp_pkg::ST_DESEL;
      rd_pend_r <= 1'b0;
      drive_r <= 1'b0;
      sleeping_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sleeping_o <= (state_nxt == pbsp_pkg::ST_SLEEP);
      rd_pend_r <= rd_now;
      // A read fresh out of deselect has no pending data yet, so the pins
      // stay released for that first cycle; a write releases them too
      drive_r <= rd_pend_r && !wr_now && !sleep_req_i;
    end
  end

  // ----------------------------------------------------------------------
  // Address and burst registers
  // ----------------------------------------------------------------------

  // No reset here: contents come only from strobed inputs and burst advances
  always_ff @(posedge clock_i) begin
    if (start) begin
      addr_r <= addr_i;
      cnt_r <= pbsp_pkg::CNT_START;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Read address pipeline stage
  always_ff @(posedge clock_i) begin
    if (rd_now) begin
      rd_addr_r <= acc_addr;
    end
  end

  // ----------------------------------------------------------------------
  // Output register and pin enables
  // ----------------------------------------------------------------------

  // Output word is reset so the pins carry no unknowns before the first read
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_r.data <= pbsp_pkg::DATA_RST;
      out_r.par <= pbsp_pkg::PAR_RST;
    end else if (rd_pend_r) begin
      out_r <= rd_word;
    end
  end

  assign lane_data_o = out_r.data;
  assign lane_parity_o = out_r.par;

  // Output enable is not clocked: it gates the registered drive at once
  assign lane_oe_o = {LN{drive_r && !out_en_n_i}};

endmodule : pbsp_core

// file: src/pbsp_pkg.sv
// Shared constants and carrier types for the pipelined burst memory port
package pbsp_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int LANES = 4;
  localparam int LANE_DW = 8;
  localparam int LANE_PW = 1;
  localparam int DATA_W = LANES * LANE_DW;
  localparam int PAR_W = LANES * LANE_PW;
  localparam int BUF_DEPTH = 2;

  // ----------------------------------------------------------------------
  // Burst counter
  // ----------------------------------------------------------------------
  localparam int CNT_W = 2;
  localparam logic [1:0] CNT_START = 2'h0;
  localparam logic [1:0] CNT_STEP = 2'h1;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [PAR_W-1:0] PAR_RST = 4'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_DESEL = 3'b001,
    ST_SEL = 3'b010,
    ST_SLEEP = 3'b100
  } pbsp_state_t;

  // One stored word: parity lanes and data lanes
  typedef struct packed {
    logic [PAR_W-1:0] par;
    logic [DATA_W-1:0] data;
  } pbsp_word_t;

  // One pending write on its way to the array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] mask;
    pbsp_word_t word;
  } pbsp_wr_t;

  localparam int WR_W = $bits(pbsp_wr_t);

endpackage : pbsp_pkg
